// ### gdc_pkg.sv
// gdc_pkg: constants and types for the gate-driver command and mode block.
// assumes a 16-bit word arrives already deserialised from the serial link.
// How it works
// - exit-config command moves configuration to configured
// - exit-config elsewhere is discarded, flags error
// - no-op does nothing, answered with a zero body plus parity
// - read request returns register value next
// - active modes restrict readable addresses
// - write-high loads only buffer upper byte
// - write-low supplies low byte: six data bits, bits 1:0 zero
// - write-low commits buffer then clears it
// - write-low target checked per mode
// - exactly one of seven modes, reported
// - full turn-on only active, weak only weak-active
// - class A events turn off, set error
// - class A: active to configured, weak to verification
// - class A fault pin on transition, or on ADC boundary in any mode
// - class B events turn off, force error mode
// - class B fault pin only on entering error
// - class C flagged, mode unchanged
// - mode commands and sticky-clear steer modes
// - emergency turn-off on class A, B, reset
// - re-enable blocked 256 oscillator cycles
// - active reached only via commands plus enable
// - odd parity in word bit zero
// - link error discards word, sets notification
// - enable rising: configured to active, verification to weak
// - enter-config accepted only in default or error
package gdc_pkg;
	typedef enum logic [2:0]
	{
		default_mode,
		error_mode,
		configuration_mode,
		configured_mode,
		active_mode,
		verification_mode,
		weak_active_mode
	} gdc_mode_t;
	localparam logic [15:0] ENTER_CFG_WORD = 16'h1880;
	localparam logic [15:0] ENTER_VER_WORD = 16'h1140;
	localparam logic [15:0] EXIT_CFG_WORD = 16'h1220;
	localparam logic [15:0] NOP_WORD = 16'h1410;
	localparam logic [15:0] READ_MASK = 16'hF07E;
	localparam logic [15:0] READ_PAT = 16'h002A;
	localparam logic [15:0] WRH_MASK = 16'hFE00;
	localparam logic [15:0] WRH_PAT = 16'h4400;
	localparam logic [15:0] WRL_MASK = 16'hF000;
	localparam logic [15:0] WRL_PAT = 16'hA000;
	localparam int ADDR_LSB = 7;
	localparam int DATA_LSB = 1;
	localparam logic [15:0] ERR_NOTE_BIT = 16'h0002;
	localparam logic [4:0] CTRL_ADDR = 5'h00;
	localparam logic [4:0] RESTRICT_LIMIT = 5'h0F;
	localparam int CLRS_BIT = 1;
	localparam int ETO_CYCLES = 256;
endpackage : gdc_pkg

// ### gdc_mode_fsm.sv
// gdc_mode_fsm: decodes request words, keeps the operating mode, drives
// faults and turn-on permission. assumes event inputs are synchronous
// pulses; enable and the oscillator clock are asynchronous pins.
module gdc_mode_fsm
	import gdc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// received word
	input wire logic wordValid,
	input wire logic [15:0] rxWord,
	input wire logic parityCheckEnable,
	// register read data and write port
	input wire logic [15:0] regReadData,
	output logic [4:0] regAddr,
	output logic regWrite,
	output logic [15:0] regWriteData,
	// answer word
	output logic [15:0] txWord,
	// events
	input wire logic desaturationEvent,
	input wire logic overcurrentEvent,
	input wire logic adcBoundaryEvent,
	input wire logic secondaryUndervoltageEvent,
	input wire logic verifyTimeoutEvent,
	input wire logic shootThroughEvent,
	input wire logic enablePin,
	input wire logic secondaryOscillator,
	// status and output control
	output gdc_pkg::gdc_mode_t modeStatusField,
	output logic spiErrorFlag,
	output logic classCFlag,
	output logic [3:0] classAErrBits,
	output logic [1:0] classBErrBits,
	output logic fullTurnOnAllowed,
	output logic weakTurnOnAllowed,
	output logic safeTurnOff,
	output logic regularTurnOff,
	output logic reenableBlocked,
	output logic class_a_fault_out_n,
	output logic class_b_fault_out_n
);
	import gdc_pkg::*;

	function automatic logic isRestricted(input gdc_mode_t m,
		input logic [4:0] a);
		isRestricted = (m == active_mode || m == weak_active_mode)
			&& (a > RESTRICT_LIMIT);
	endfunction : isRestricted

	gdc_mode_t mode_q, mode_d;
	logic [15:0] wbuf_q, wbuf_d, tx_q, tx_d, wdata_q, wdata_d;
	logic [4:0] addr_q, addr_d;
	logic wr_q, wr_d, spiErr_q, spiErr_d, cFlag_q, cFlag_d;
	logic [3:0] aErr_q, aErr_d;
	logic [1:0] bErr_q, bErr_d;
	logic fa_q, fa_d, fb_q, fb_d, safe_q, safe_d, reg_q, reg_d;
	logic en1_q, en2_q, en3_q, os1_q, os2_q, os3_q;
	logic [8:0] eto_q, eto_d;
	logic pendCfg_q, pendCfg_d, init_q;

	logic enRise, enFall, oscTick, classA, classB, parityOk, bad;
	logic [4:0] wAddr;

	assign enRise = en2_q & ~en3_q;
	assign enFall = ~en2_q & en3_q;
	assign oscTick = os2_q & ~os3_q;
	assign classA = desaturationEvent | overcurrentEvent | enFall
		| adcBoundaryEvent;
	assign classB = secondaryUndervoltageEvent | verifyTimeoutEvent;
	assign parityOk = ^rxWord | ~parityCheckEnable;
	assign wAddr = rxWord[ADDR_LSB +: 5];

	always_comb
	begin
		mode_d = mode_q;
		wbuf_d = wbuf_q;
		tx_d = tx_q;
		addr_d = addr_q;
		wr_d = 1'b0;
		wdata_d = wdata_q;
		spiErr_d = spiErr_q;
		cFlag_d = cFlag_q | shootThroughEvent;
		aErr_d = aErr_q | {adcBoundaryEvent, enFall, overcurrentEvent,
			desaturationEvent};
		bErr_d = bErr_q | {verifyTimeoutEvent, secondaryUndervoltageEvent};
		fa_d = 1'b0;
		fb_d = 1'b0;
		safe_d = desaturationEvent | overcurrentEvent;
		reg_d = enFall | adcBoundaryEvent | classB;
		eto_d = eto_q;
		pendCfg_d = pendCfg_q;
		bad = 1'b0;
		if (oscTick && eto_q != 9'h000)
			eto_d = eto_q - 9'h001;
		if (wordValid)
		begin
			tx_d = {tx_q[15:1], 1'b0};
			if (rxWord == NOP_WORD)
				bad = 1'b0;
			else if (rxWord == ENTER_CFG_WORD)
			begin
				if (mode_q == default_mode || mode_q == error_mode)
					pendCfg_d = 1'b1;
				else
					bad = 1'b1;
			end
			else if (rxWord == ENTER_VER_WORD)
			begin
				if (mode_q == configuration_mode)
					mode_d = verification_mode;
				else
					bad = 1'b1;
			end
			else if (rxWord == EXIT_CFG_WORD)
			begin
				if (mode_q == configuration_mode)
					mode_d = configured_mode;
				else
					bad = 1'b1;
			end
			else if (!parityOk)
				bad = 1'b1;
			else if ((rxWord & READ_MASK) == READ_PAT)
			begin
				if (isRestricted(mode_q, wAddr))
					bad = 1'b1;
				else
					addr_d = wAddr;
			end
			else if ((rxWord & WRH_MASK) == WRH_PAT)
				wbuf_d[15:8] = rxWord[DATA_LSB +: 8];
			else if ((rxWord & WRL_MASK) == WRL_PAT)
			begin
				if (isRestricted(mode_q, wAddr))
					bad = 1'b1;
				else
				begin
					addr_d = wAddr;
					wr_d = 1'b1;
					wdata_d = {wbuf_q[15:8], rxWord[DATA_LSB +: 6],
						2'b00};
					wbuf_d = 16'h0000;
					if (wAddr == CTRL_ADDR && rxWord[DATA_LSB + CLRS_BIT]
						&& mode_q == error_mode && !classB)
						mode_d = default_mode;
				end
			end
			else
				bad = 1'b1;
			if (bad)
			begin
				spiErr_d = 1'b1;
				cFlag_d = 1'b1;
			end
		end
		if (pendCfg_q && !classB)
		begin
			mode_d = configuration_mode;
			pendCfg_d = 1'b0;
		end
		if (enRise && eto_q == 9'h000)
		begin
			if (mode_q == configured_mode)
				mode_d = active_mode;
			else if (mode_q == verification_mode)
				mode_d = weak_active_mode;
		end
		if (classA)
		begin
			if (mode_q == active_mode)
			begin
				mode_d = configured_mode;
				fa_d = 1'b1;
			end
			else if (mode_q == weak_active_mode)
			begin
				mode_d = verification_mode;
				fa_d = 1'b1;
			end
			else if (adcBoundaryEvent)
				fa_d = 1'b1;
			eto_d = 9'(ETO_CYCLES);
		end
		if (classB)
		begin
			if (mode_q != error_mode)
				fb_d = 1'b1;
			mode_d = error_mode;
			eto_d = 9'(ETO_CYCLES);
		end
	end

	// state registers, updated on clkEn; reset loads default mode and regular turn-off
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mode_q <= default_mode;
			wbuf_q <= 16'h0000;
			tx_q <= 16'h0000;
			addr_q <= 5'h00;
			wr_q <= 1'b0;
			wdata_q <= 16'h0000;
			spiErr_q <= 1'b0;
			cFlag_q <= 1'b0;
			aErr_q <= 4'h0;
			bErr_q <= 2'h0;
			fa_q <= 1'b0;
			fb_q <= 1'b0;
			safe_q <= 1'b0;
			reg_q <= 1'b1;
			eto_q <= 9'h000;
			pendCfg_q <= 1'b0;
			en1_q <= 1'b0;
			en2_q <= 1'b0;
			en3_q <= 1'b0;
			os1_q <= 1'b0;
			os2_q <= 1'b0;
			os3_q <= 1'b0;
			init_q <= 1'b0;
		end
		else if (clkEn)
		begin
			mode_q <= mode_d;
			wbuf_q <= wbuf_d;
			tx_q <= tx_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
			wdata_q <= wdata_d;
			spiErr_q <= spiErr_d;
			cFlag_q <= cFlag_d;
			aErr_q <= aErr_d;
			bErr_q <= bErr_d;
			fa_q <= fa_d;
			fb_q <= fb_d;
			safe_q <= safe_d;
			reg_q <= reg_d | ~init_q;
			eto_q <= init_q ? eto_d : 9'(ETO_CYCLES);
			pendCfg_q <= pendCfg_d;
			en1_q <= enablePin;
			en2_q <= en1_q;
			en3_q <= en2_q;
			os1_q <= secondaryOscillator;
			os2_q <= os1_q;
			os3_q <= os2_q;
			init_q <= 1'b1;
		end
	end

	// answer: error notification marks a refused word; parity is odd
	logic [15:0] ansBody;
	logic ansRead;
	assign ansRead = wordValid && parityOk && !bad
		&& (rxWord & READ_MASK) == READ_PAT;
	assign ansBody = ansRead ? {regReadData[15:1], 1'b0}
		: ({tx_q[15:1], 1'b0} | (bad ? ERR_NOTE_BIT : 16'h0000));
	logic [15:0] txReg_q;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			txReg_q <= 16'h0001;
		else if (clkEn && wordValid)
			txReg_q <= {ansBody[15:1], ~^ansBody[15:1]};
	end

	assign txWord = txReg_q;
	assign modeStatusField = mode_q;
	assign regAddr = addr_q;
	assign regWrite = wr_q;
	assign regWriteData = wdata_q;
	assign spiErrorFlag = spiErr_q;
	assign classCFlag = cFlag_q;
	assign classAErrBits = aErr_q;
	assign classBErrBits = bErr_q;
	assign fullTurnOnAllowed = (mode_q == active_mode) && !reg_q
		&& !safe_q;
	assign weakTurnOnAllowed = (mode_q == weak_active_mode) && !reg_q
		&& !safe_q;
	assign safeTurnOff = safe_q;
	assign regularTurnOff = reg_q;
	assign reenableBlocked = (eto_q != 9'h000);
	assign class_a_fault_out_n = ~fa_q;
	assign class_b_fault_out_n = ~fb_q;

	a_exit_cfg_mode: assert property (@(posedge clk) disable iff (reset)
		clkEn && wordValid && rxWord == EXIT_CFG_WORD
		&& mode_q == configuration_mode && !classA && !classB
		|=> mode_q == configured_mode)
		else $error("exit command did not reach configured mode");
	a_exit_bad_err: assert property (@(posedge clk) disable iff (reset)
		clkEn && wordValid && rxWord == EXIT_CFG_WORD
		&& mode_q != configuration_mode |=> spiErrorFlag && txWord[1])
		else $error("misplaced exit command not flagged");
	a_fault_a_only: assert property (@(posedge clk) disable iff (reset)
		clkEn && !class_a_fault_out_n |-> $past(mode_q) != mode_q
		|| $past(adcBoundaryEvent))
		else $error("class A fault without transition");
	a_fault_b_entry: assert property (@(posedge clk) disable iff (reset)
		!class_b_fault_out_n |-> mode_q == error_mode
		&& $past(mode_q) != error_mode)
		else $error("class B fault without entry to error mode");
	a_classb_err: assert property (@(posedge clk) disable iff (reset)
		clkEn && classB |=> mode_q == error_mode)
		else $error("class B did not force error mode");
	a_full_on_active: assert property (@(posedge clk) disable iff (reset)
		fullTurnOnAllowed |-> mode_q == active_mode && !weakTurnOnAllowed)
		else $error("full turn-on outside active mode");
	a_active_via_cfg: assert property (@(posedge clk) disable iff (reset)
		clkEn && mode_q != active_mode ##1 mode_q == active_mode
		|-> $past(mode_q) == configured_mode)
		else $error("active mode entered from wrong mode");
	a_enter_cfg_only: assert property (@(posedge clk) disable iff (reset)
		mode_q == configuration_mode && $past(mode_q) != configuration_mode
		|-> $past(pendCfg_q))
		else $error("configuration entered without command");
	a_write_clears: assert property (@(posedge clk) disable iff (reset)
		regWrite |-> wbuf_q == 16'h0000)
		else $error("write buffer not cleared after commit");
	a_eto_block: assert property (@(posedge clk) disable iff (reset)
		clkEn && init_q && (classA || classB) |=> reenableBlocked)
		else $error("re-enable not blocked after turn-off");
	a_mode_legal: assert property (@(posedge clk) disable iff (reset)
		mode_q inside {default_mode, error_mode, configuration_mode,
		configured_mode, active_mode, verification_mode, weak_active_mode})
		else $error("mode register left the seven modes");
	a_nop_quiet: assert property (@(posedge clk) disable iff (reset)
		clkEn && wordValid && rxWord == NOP_WORD && !classA && !classB
		&& !pendCfg_q && !enRise |=> $stable(mode_q) && !regWrite)
		else $error("no-op command changed state");
	a_class_a_drop: assert property (@(posedge clk) disable iff (reset)
		clkEn && classA && !classB && mode_q == active_mode
		|=> mode_q == configured_mode && !class_a_fault_out_n)
		else $error("class A did not drop active mode");
	a_bad_word_note: assert property (@(posedge clk) disable iff (reset)
		clkEn && wordValid && bad |=> spiErrorFlag && txWord[1])
		else $error("refused word not notified");
	a_write_high: assert property (@(posedge clk) disable iff (reset)
		clkEn && wordValid && parityOk && (rxWord & WRH_MASK) == WRH_PAT
		|=> !regWrite && wbuf_q[15:8] == $past(rxWord[8:1]))
		else $error("write-high did more than load the buffer");
	a_off_when_idle: assert property (@(posedge clk) disable iff (reset)
		mode_q != active_mode && mode_q != weak_active_mode
		|-> !fullTurnOnAllowed && !weakTurnOnAllowed)
		else $error("turn-on allowed in a disabled mode");
endmodule : gdc_mode_fsm

// ### gdc_host_model.sv
// gdc_host_model: the controlling master that hands request words to the
// block. assumes words are presented whole, one per accepted clock edge.
module gdc_host_model
	import gdc_pkg::*;
(
	// clock
	input wire logic clk,
	// request word
	output logic wordValid,
	output logic [15:0] rxWord
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		wordValid = 1'b0;
		rxWord = 16'h0000;
	end

	function automatic logic [15:0] withParity(input logic [15:0] w);
		return {w[15:1], ~^w[15:1]};
	endfunction : withParity

	// a released word line shows the inverse, never the stale request
	task automatic sendRaw(input logic [15:0] w, input int idle);
		repeat (idle) @(negedge clk);
		@(negedge clk);
		wordValid = 1'b1;
		rxWord = w;
		@(negedge clk);
		wordValid = 1'b0;
		rxWord = ~w;
	endtask : sendRaw

	task automatic sendWord(input logic [15:0] w);
		sendRaw(withParity(w), 0);
	endtask : sendWord

	task automatic readWord(input logic [4:0] a);
		sendWord(READ_PAT | (16'(a) << ADDR_LSB));
	endtask : readWord

	task automatic writeHigh(input logic [7:0] d);
		sendWord(WRH_PAT | (16'(d) << DATA_LSB));
	endtask : writeHigh

	task automatic writeLow(input logic [4:0] a, input logic [5:0] d);
		sendWord(WRL_PAT | (16'(a) << ADDR_LSB) | (16'(d) << DATA_LSB));
	endtask : writeLow
endmodule : gdc_host_model

// ### tb_gdc_mode_fsm.sv
// tb_gdc_mode_fsm: self-checking bench for the command and mode block.
// assumes the host model drives words; the bench models the register map.
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin \
	nErrors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_gdc_mode_fsm
	import gdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset, clkEn, parityCheckEnable, enablePin, osc;
	logic wordValid, regWrite, spiErrorFlag, classCFlag, fullOn, weakOn;
	logic safeOff, regularOff, reenableBlocked, faultAN, faultBN;
	logic [15:0] rxWord, regReadData, regWriteData, txWord;
	logic [4:0] regAddr;
	logic [5:0] ev;
	logic [3:0] classAErrBits;
	logic [1:0] classBErrBits;
	gdc_mode_t mode;
	int nErrors = 0;
	int nCompared = 0;
	int cycles = 0;

	assign regReadData = {6'h2C, rxWord[11:7], 5'h00};
	gdc_host_model host (.clk(clk), .wordValid(wordValid), .rxWord(rxWord));
	gdc_mode_fsm uut (.clk(clk), .reset(reset), .clkEn(clkEn),
		.wordValid(wordValid), .rxWord(rxWord),
		.parityCheckEnable(parityCheckEnable), .regReadData(regReadData),
		.regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
		.txWord(txWord), .desaturationEvent(ev[0]), .overcurrentEvent(ev[1]),
		.adcBoundaryEvent(ev[2]), .secondaryUndervoltageEvent(ev[3]),
		.verifyTimeoutEvent(ev[4]), .shootThroughEvent(ev[5]),
		.enablePin(enablePin), .secondaryOscillator(osc),
		.modeStatusField(mode), .spiErrorFlag(spiErrorFlag),
		.classCFlag(classCFlag), .classAErrBits(classAErrBits),
		.classBErrBits(classBErrBits), .fullTurnOnAllowed(fullOn),
		.weakTurnOnAllowed(weakOn), .safeTurnOff(safeOff),
		.regularTurnOff(regularOff), .reenableBlocked(reenableBlocked),
		.class_a_fault_out_n(faultAN), .class_b_fault_out_n(faultBN));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// free-running oscillator, phase unrelated to clk
	initial
	begin
		osc = 1'b0;
		#13;
		forever #40 osc = ~osc;
	end

	task automatic wrapUp();
		$display("compared %0d, errors %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrapUp

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nErrors++;
			wrapUp();
		end
	end

	task automatic pulse(input logic [5:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 6'h00;
	endtask : pulse

	// waits out the turn-off block; returns the cycles it took
	task automatic waitUnblocked(output int n);
		n = 0;
		while (reenableBlocked === 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
	endtask : waitUnblocked

	task automatic tErrors();
		host.sendWord(NOP_WORD);
		`CHK("nopMode", default_mode, mode)
		`CHK("nopNote", 1'b0, txWord[1])
		`CHK("txParity", 1'b1, ^txWord)
		host.sendWord(EXIT_CFG_WORD);
		`CHK("exitMode", default_mode, mode)
		`CHK("exitNote", 1'b1, txWord[1])
		`CHK("spiErr", 1'b1, spiErrorFlag)
		host.sendRaw(host.withParity(READ_PAT) ^ 16'h0001, 2);
		`CHK("parNote", 1'b1, txWord[1])
		parityCheckEnable = 1'b0;
		host.sendRaw(host.withParity(READ_PAT) ^ 16'h0001, 2);
		`CHK("parOff", 1'b0, txWord[1])
		`CHK("parOffData", 15'h5800, txWord[15:1])
		parityCheckEnable = 1'b1;
	endtask : tErrors

	task automatic tBringUp(input int start);
		int n;
		logic seen;
		waitUnblocked(n);
		`CHK("etoSpan", 1'b1, n + start > 1990 && n + start < 2100)
		host.sendWord(ENTER_CFG_WORD);
		@(negedge clk);
		`CHK("cfgMode", configuration_mode, mode)
		`CHK("offCfg", 1'b0, fullOn)
		host.sendWord(EXIT_CFG_WORD);
		`CHK("exitOk", configured_mode, mode)
		enablePin = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("actMode", active_mode, mode)
		`CHK("fullOn", 1'b1, fullOn)
		host.readWord(5'h10);
		`CHK("rdLimit", 1'b1, txWord[1])
		host.writeLow(5'h10, 6'h00);
		`CHK("wrLimit", 1'b1, txWord[1])
		`CHK("wrNone", 1'b0, regWrite)
		host.readWord(5'h02);
		`CHK("rdData", {6'h2C, 5'h02, 4'h0}, txWord[15:1])
		pulse(6'h01);
		`CHK("desatMode", configured_mode, mode)
		`CHK("faultA", 1'b0, faultAN)
		`CHK("safeOff", 1'b1, safeOff)
		`CHK("desatBit", 1'b1, classAErrBits[0])
		enablePin = 1'b0;
		seen = 1'b0;
		repeat (8)
		begin
			@(negedge clk);
			seen |= ~faultAN;
		end
		`CHK("noFaultA", 1'b0, seen)
		`CHK("enFallBit", 1'b1, classAErrBits[2])
		pulse(6'h04);
		`CHK("adcFault", 1'b0, faultAN)
		`CHK("adcMode", configured_mode, mode)
		`CHK("adcBit", 1'b1, classAErrBits[3])
	endtask : tBringUp

	task automatic tWrites();
		host.writeHigh(8'hA5);
		`CHK("whOnly", 1'b0, regWrite)
		host.writeLow(5'h03, 6'h15);
		`CHK("wlStrobe", 1'b1, regWrite)
		`CHK("wlAddr", 5'h03, regAddr)
		`CHK("wlData", 16'hA554, regWriteData)
		host.writeLow(5'h04, 6'h3F);
		`CHK("wlClear", 16'h00FC, regWriteData)
	endtask : tWrites

	task automatic tClassB();
		int n;
		pulse(6'h20);
		`CHK("ccFlag", 1'b1, classCFlag)
		`CHK("ccMode", configured_mode, mode)
		pulse(6'h08);
		`CHK("uvMode", error_mode, mode)
		`CHK("faultB", 1'b0, faultBN)
		`CHK("uvOff", 1'b1, regularOff)
		`CHK("uvBit", 1'b1, classBErrBits[0])
		pulse(6'h08);
		`CHK("noFaultB", 1'b1, faultBN)
		host.sendWord(ENTER_CFG_WORD);
		@(negedge clk);
		host.sendWord(ENTER_VER_WORD);
		`CHK("verMode", verification_mode, mode)
		waitUnblocked(n);
		enablePin = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("weakMode", weak_active_mode, mode)
		`CHK("weakOn", 2'b01, {fullOn, weakOn})
		pulse(6'h01);
		`CHK("weakBack", verification_mode, mode)
		`CHK("weakFault", 1'b0, faultAN)
		pulse(6'h10);
		`CHK("toMode", error_mode, mode)
		`CHK("toFault", 1'b0, faultBN)
		`CHK("toBit", 2'b11, classBErrBits)
	endtask : tClassB

	// reset in mid-run, then events and sticky-clear from a clean start
	task automatic tReset();
		@(negedge clk);
		reset = 1'b1;
		@(negedge clk);
		`CHK("rrMode", default_mode, mode)
		`CHK("rrOff", 1'b1, regularOff)
		`CHK("rrFlag", 1'b0, classCFlag)
		reset = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("rrBlock", 1'b1, reenableBlocked)
		`CHK("rrFaults", 2'b11, {faultAN, faultBN})
		pulse(6'h22);
		`CHK("ocpMode", default_mode, mode)
		`CHK("ocpSafe", 1'b1, safeOff)
		`CHK("ocpBit", 4'h2, classAErrBits)
		`CHK("ocpFault", 1'b1, faultAN)
		`CHK("stFlag", 1'b1, classCFlag)
		pulse(6'h08);
		`CHK("uv2Mode", error_mode, mode)
		host.writeLow(CTRL_ADDR, 6'h02);
		`CHK("clrMode", default_mode, mode)
	endtask : tReset

	initial
	begin
		reset = 1'b1;
		clkEn = 1'b1;
		parityCheckEnable = 1'b1;
		enablePin = 1'b0;
		ev = 6'h00;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		`CHK("rstMode", default_mode, mode)
		`CHK("rstOff", 1'b1, regularOff)
		repeat (2) @(negedge clk);
		`CHK("rstBlock", 1'b1, reenableBlocked)
		tErrors();
		tBringUp(cycles);
		tWrites();
		tClassB();
		tReset();
		wrapUp();
	end
endmodule : tb_gdc_mode_fsm
